// *** logic/hub_up_tx_consts.vh ***
// Constants for the upstream transmit scheduler of a hub.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef HUB_UP_TX_CONSTS_VH
`define HUB_UP_TX_CONSTS_VH

// Symbols between SKP ordered sets; a plain default, shorten in benches.
`define SKIP_SYMBOL_LIMIT     256
// Forwarding delay variation allowed downstream, in ns, and in cycles.
`define PROP_JITTER_LIMIT_NS  0
`define CLK_PERIOD_NS         5
`define PROP_JITTER_CYCLES    (`PROP_JITTER_LIMIT_NS / `CLK_PERIOD_NS)
// Header packets held for upstream transmission.
`define HDR_QUEUE_DEPTH       8
`define HDR_SYMBOLS           5
`define LCMD_SYMBOLS          2

// Symbol kinds on the transmit output.
`define KIND_IDLE             3'h0
`define KIND_SKP              3'h1
`define KIND_LCMD             3'h2
`define KIND_HDR              3'h3
`define KIND_DATA             3'h4
`define KIND_END              3'h5
`define KIND_ABORT            3'h6

// Origins of a pending SKP ordered set.
`define SRC_LCMD              2'h0
`define SRC_HDR               2'h1
`define SRC_PAY               2'h2

`endif

// *** logic/hub_upstream_tx_scheduler.v ***
// Upstream-facing transmit scheduler of a hub, with downstream header dispatch.
// Assumes a link-clock domain shared with the link layer, queues on the same
// clock, and a payload store that holds each payload whole before it starts.
//
// What this block does
// RULE_01 - Data header and payload leave back to back, nothing between them.
// RULE_02 - Downstream header forwarding delay to a U0 port never varies.
// RULE_03 - Eight headers to one non-U0 downstream port fit before credits end; held by the port buffers downstream, not here.
// RULE_04 - Downstream header goes to its port at once, whatever others hold.
// RULE_05 - Eight upstream-bound headers are held while the upstream is not U0.
// RULE_06 - Downstream ports send headers in upstream arrival order.
// RULE_07 - Upstream sends headers from one downstream port in arrival order.
// RULE_08 - Keep a running count of transmitted symbols for SKP scheduling.
// RULE_09 - Return to idle on U0 entry, after packets, after last command.
// RULE_10 - Idle with count at limit sends one SKP and zeroes the count.
// RULE_11 - A header packet is never cut short by an abort.
// RULE_12 - Start a header from idle only when no link command waits.
// RULE_13 - After a lone header, one SKP if count at limit, minus limit.
// RULE_14 - Payload follows the data header's last symbol immediately.
// RULE_15 - Never resend a payload; release it after end and owed SKPs.
// RULE_16 - After a normal payload, repeat SKP while count at limit.
// RULE_17 - Downstream abort or babble switches data to abort, then release.
// RULE_18 - After an abort, repeat SKP while count at limit.
// RULE_19 - Queued link commands go out with no idle gap, SKP alone between.
// RULE_20 - Enter and stay in link-command sending while any is queued.
// RULE_21 - After each link command, one SKP if count at limit, minus limit.
// RULE_22 - Clear the symbol count whenever the link enters U0.
`include "hub_up_tx_consts.vh"

module hub_upstream_tx_scheduler #(
  parameter SYM_W      = 32,
  parameter CNT_W      = 16,
  parameter SKIP_LIMIT = `SKIP_SYMBOL_LIMIT,
  parameter HDR_DEPTH  = `HDR_QUEUE_DEPTH,
  parameter HDR_LEN    = `HDR_SYMBOLS,
  parameter LCMD_LEN   = `LCMD_SYMBOLS,
  parameter PORTS      = 4,
  parameter PORT_W     = 2,
  parameter PTR_W      = 3
) (
  input  wire                       sys_clk_in,
  input  wire                       rst_in,
  input  wire                       clk_en_in,
  input  wire                       link_u0_in,
  input  wire                       lcmd_valid_in,
  input  wire [SYM_W-1:0]           lcmd_word_in,
  output wire                       lcmd_ready_out,
  input  wire                       up_hdr_valid_in,
  input  wire [HDR_LEN*SYM_W-1:0]   up_hdr_in,
  input  wire                       up_hdr_pay_in,
  output wire                       up_hdr_ready_out,
  input  wire                       pay_valid_in,
  input  wire [SYM_W-1:0]           pay_data_in,
  input  wire                       pay_last_in,
  input  wire                       pay_abort_in,
  output wire                       pay_ready_out,
  output reg                        pay_release_out,
  output reg  [SYM_W-1:0]           tx_sym_out,
  output reg  [2:0]                 tx_kind_out,
  output wire [CNT_W-1:0]           sym_count_out,
  input  wire                       dn_hdr_valid_in,
  input  wire [PORT_W-1:0]          dn_hdr_port_in,
  input  wire [HDR_LEN*SYM_W-1:0]   dn_hdr_in,
  output wire                       dn_hdr_ready_out,
  input  wire [PORTS-1:0]           dn_port_ready_in,
  output wire [PORTS-1:0]           dn_port_valid_out,
  output wire [HDR_LEN*SYM_W-1:0]   dn_port_hdr_out
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_LCMD  = 3'h1;
  localparam ST_HDR   = 3'h2;
  localparam ST_DATA  = 3'h3;
  localparam ST_END   = 3'h4;
  localparam ST_SKP   = 3'h5;
  localparam HW       = HDR_LEN * SYM_W;
  localparam [CNT_W-1:0] LIMIT = SKIP_LIMIT;
  localparam [7:0] HDR_LAST  = HDR_LEN - 1;
  localparam [7:0] LCMD_LAST = LCMD_LEN - 1;

  // Test whether the symbol count has reached the limit.
  function at_limit;
    input [CNT_W-1:0] cnt;
    begin
      at_limit = (cnt >= LIMIT);
    end
  endfunction

  // Downstream dispatch is a pure wire path: zero added delay, hence zero
  // variation, and a full port never blocks a header bound elsewhere. The
  // eight-deep absorption per port relies on the port buffers downstream.
  assign dn_port_valid_out = dn_hdr_valid_in ?
                             ({{(PORTS-1){1'b0}}, 1'b1} << dn_hdr_port_in) :
                             {PORTS{1'b0}}; // RULE_04
  assign dn_hdr_ready_out  = dn_port_ready_in[dn_hdr_port_in]; // RULE_02
  assign dn_port_hdr_out   = dn_hdr_in; // RULE_06

  // Upstream header queue, filled regardless of link state.
  reg  [HW-1:0]    hdr_mem [0:HDR_DEPTH-1];
  reg  [HDR_DEPTH-1:0] hdr_pay_mem;
  reg  [PTR_W:0]   wr_ptr_q;
  reg  [PTR_W:0]   rd_ptr_q;
  wire             hdr_empty;
  wire             hdr_full;
  wire             hdr_push;
  reg              hdr_pop;

  assign hdr_empty = (wr_ptr_q == rd_ptr_q);
  assign hdr_full  = (wr_ptr_q[PTR_W] != rd_ptr_q[PTR_W]) &&
                     (wr_ptr_q[PTR_W-1:0] == rd_ptr_q[PTR_W-1:0]);
  assign up_hdr_ready_out = !hdr_full; // RULE_05
  assign hdr_push  = up_hdr_valid_in && !hdr_full && clk_en_in;

  always @(posedge sys_clk_in) begin
    if (hdr_push) begin
      hdr_mem[wr_ptr_q[PTR_W-1:0]]     <= up_hdr_in; // RULE_05
      hdr_pay_mem[wr_ptr_q[PTR_W-1:0]] <= up_hdr_pay_in;
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= {(PTR_W+1){1'b0}};
      rd_ptr_q <= {(PTR_W+1){1'b0}};
    end else if (clk_en_in) begin
      if (hdr_push)
        wr_ptr_q <= wr_ptr_q + 1'b1; // RULE_07
      if (hdr_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // Transmit sequencer.
  reg  [2:0]       state_q, state_d;
  reg  [7:0]       idx_q, idx_d;
  reg  [CNT_W-1:0] cnt_q, cnt_d;
  reg  [SYM_W-1:0] lcmd_q, lcmd_d;
  reg  [HW-1:0]    hdr_q, hdr_d;
  reg              hpay_q, hpay_d;
  reg  [1:0]       src_q, src_d;
  reg              rep_q, rep_d;
  reg  [SYM_W-1:0] sym_d;
  reg  [2:0]       kind_d;
  reg              lcmd_pop;
  reg              pay_take;
  reg              release_d;
  wire [CNT_W-1:0] cnt_inc;
  wire [CNT_W-1:0] cnt_sub;

  assign cnt_inc        = cnt_q + 1'b1;
  assign cnt_sub        = cnt_q - LIMIT;
  assign lcmd_ready_out = lcmd_pop;
  assign pay_ready_out  = pay_take;
  assign sym_count_out  = cnt_q;

  always @* begin
    state_d   = state_q;
    idx_d     = idx_q;
    cnt_d     = cnt_inc; // RULE_08
    lcmd_d    = lcmd_q;
    hdr_d     = hdr_q;
    hpay_d    = hpay_q;
    src_d     = src_q;
    rep_d     = rep_q;
    sym_d     = {SYM_W{1'b0}};
    kind_d    = `KIND_IDLE;
    lcmd_pop  = 1'b0;
    hdr_pop   = 1'b0;
    pay_take  = 1'b0;
    release_d = 1'b0;
    if (!link_u0_in) begin
      state_d = ST_IDLE; // RULE_09
      cnt_d   = {CNT_W{1'b0}}; // RULE_22
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (at_limit(cnt_q)) begin
            kind_d = `KIND_SKP;
            cnt_d  = {CNT_W{1'b0}}; // RULE_10
          end else if (lcmd_valid_in) begin
            lcmd_pop = 1'b1; // RULE_20
            lcmd_d   = lcmd_word_in;
            idx_d    = 8'h00;
            state_d  = ST_LCMD;
          end else if (!hdr_empty) begin
            hdr_pop = 1'b1; // RULE_12
            hdr_d   = hdr_mem[rd_ptr_q[PTR_W-1:0]];
            hpay_d  = hdr_pay_mem[rd_ptr_q[PTR_W-1:0]];
            idx_d   = 8'h00;
            state_d = ST_HDR;
          end
        end
        ST_LCMD: begin
          kind_d = `KIND_LCMD;
          sym_d  = lcmd_q;
          idx_d  = idx_q + 8'h01;
          if (idx_q == LCMD_LAST) begin
            if (at_limit(cnt_inc)) begin
              state_d = ST_SKP; // RULE_21
              src_d   = `SRC_LCMD;
              rep_d   = 1'b0;
            end else if (lcmd_valid_in) begin
              lcmd_pop = 1'b1; // RULE_19
              lcmd_d   = lcmd_word_in;
              idx_d    = 8'h00;
            end else begin
              state_d = ST_IDLE; // RULE_09
            end
          end
        end
        ST_HDR: begin
          // Abort requests are not looked at here, so a header always ends.
          kind_d = `KIND_HDR; // RULE_11
          sym_d  = hdr_q[idx_q*SYM_W +: SYM_W];
          idx_d  = idx_q + 8'h01;
          if (idx_q == HDR_LAST) begin
            if (hpay_q) begin
              state_d = ST_DATA; // RULE_14
            end else if (at_limit(cnt_inc)) begin
              state_d = ST_SKP; // RULE_13
              src_d   = `SRC_HDR;
              rep_d   = 1'b0;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_DATA: begin
          // The store is complete before start, so a word is always there.
          pay_take = 1'b1; // RULE_01
          if (pay_abort_in) begin
            kind_d  = `KIND_ABORT; // RULE_17
            src_d   = `SRC_PAY;
            rep_d   = 1'b1;
            if (at_limit(cnt_inc)) begin
              state_d = ST_SKP; // RULE_18
            end else begin
              state_d   = ST_IDLE;
              release_d = 1'b1;
            end
          end else begin
            kind_d = `KIND_DATA;
            sym_d  = pay_data_in;
            if (pay_valid_in && pay_last_in)
              state_d = ST_END;
          end
        end
        ST_END: begin
          kind_d = `KIND_END;
          src_d  = `SRC_PAY;
          rep_d  = 1'b1;
          if (at_limit(cnt_inc)) begin
            state_d = ST_SKP; // RULE_16
          end else begin
            state_d   = ST_IDLE;
            release_d = 1'b1; // RULE_15
          end
        end
        ST_SKP: begin
          kind_d = `KIND_SKP;
          cnt_d  = cnt_sub;
          if (!(rep_q && at_limit(cnt_sub))) begin
            if (src_q == `SRC_LCMD && lcmd_valid_in) begin
              lcmd_pop = 1'b1; // RULE_19
              lcmd_d   = lcmd_word_in;
              idx_d    = 8'h00;
              state_d  = ST_LCMD;
            end else begin
              state_d = ST_IDLE; // RULE_09
            end
            // The payload is dropped only now, so it is never sent twice.
            if (src_q == `SRC_PAY)
              release_d = 1'b1; // RULE_15
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    if (!clk_en_in) begin
      lcmd_pop = 1'b0;
      hdr_pop  = 1'b0;
      pay_take = 1'b0;
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q         <= ST_IDLE;
      idx_q           <= 8'h00;
      cnt_q           <= {CNT_W{1'b0}};
      lcmd_q          <= {SYM_W{1'b0}};
      hdr_q           <= {HW{1'b0}};
      hpay_q          <= 1'b0;
      src_q           <= `SRC_LCMD;
      rep_q           <= 1'b0;
      tx_sym_out      <= {SYM_W{1'b0}};
      tx_kind_out     <= `KIND_IDLE;
      pay_release_out <= 1'b0;
    end else if (clk_en_in) begin
      state_q         <= state_d;
      idx_q           <= idx_d;
      cnt_q           <= cnt_d;
      lcmd_q          <= lcmd_d;
      hdr_q           <= hdr_d;
      hpay_q          <= hpay_d;
      src_q           <= src_d;
      rep_q           <= rep_d;
      tx_sym_out      <= sym_d;
      tx_kind_out     <= kind_d;
      pay_release_out <= release_d;
    end
  end

endmodule

// *** testbench/hub_up_tx_properties.sv ***
// Port assertions for the upstream transmit scheduler.
// Assumes it is bound onto the scheduler, with the count parameters passed on.
`include "hub_up_tx_consts.vh"
module hub_up_tx_properties #(
  parameter CNT_W      = 16,
  parameter SKIP_LIMIT = `SKIP_SYMBOL_LIMIT,
  parameter PORTS      = 4,
  parameter PORT_W     = 2
) (
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire logic              link_u0_in,
  input wire logic              lcmd_ready_out,
  input wire logic              pay_ready_out,
  input wire logic              pay_last_in,
  input wire logic              pay_abort_in,
  input wire logic [2:0]        tx_kind_out,
  input wire logic [CNT_W-1:0]  sym_count_out,
  input wire logic              dn_hdr_valid_in,
  input wire logic [PORT_W-1:0] dn_hdr_port_in,
  input wire logic              dn_hdr_ready_out,
  input wire logic [PORTS-1:0]  dn_port_ready_in,
  input wire logic [PORTS-1:0]  dn_port_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  u0_idle_a: assert property (!link_u0_in |=>
    tx_kind_out == `KIND_IDLE && sym_count_out == 0)
    else $error("not idle with zero count outside U0");
  hdr_whole_a: assert property (tx_kind_out == `KIND_HDR &&
    $past(tx_kind_out) != `KIND_HDR |-> tx_kind_out == `KIND_HDR [*5])
    else $error("header packet cut short");
  skp_step_a: assert property (tx_kind_out == `KIND_SKP |->
    sym_count_out == 0 || sym_count_out == $past(sym_count_out) - SKIP_LIMIT)
    else $error("SKP did not reduce the symbol count");
  pay_data_a: assert property (pay_ready_out |=>
    tx_kind_out == `KIND_DATA || tx_kind_out == `KIND_ABORT)
    else $error("payload word taken outside data");
  pay_end_a: assert property (pay_ready_out && pay_last_in &&
    !pay_abort_in |-> ##2 tx_kind_out == `KIND_END)
    else $error("no end framing after last word");
  pay_abort_a: assert property (pay_ready_out && pay_abort_in |=>
    tx_kind_out == `KIND_ABORT)
    else $error("abort not sent");
  lcmd_pair_a: assert property (lcmd_ready_out |->
    ##2 tx_kind_out == `KIND_LCMD [*2])
    else $error("link command not sent twice");
  dn_route_a: assert property (dn_hdr_valid_in |->
    dn_hdr_ready_out == dn_port_ready_in[dn_hdr_port_in] &&
    dn_port_valid_out == (1 << dn_hdr_port_in))
    else $error("downstream header misrouted");
endmodule

bind hub_upstream_tx_scheduler hub_up_tx_properties #(.CNT_W(CNT_W),
  .SKIP_LIMIT(SKIP_LIMIT), .PORTS(PORTS), .PORT_W(PORT_W)) u_props (
  .sys_clk_in, .rst_in, .link_u0_in, .lcmd_ready_out, .pay_ready_out,
  .pay_last_in, .pay_abort_in, .tx_kind_out, .sym_count_out,
  .dn_hdr_valid_in, .dn_hdr_port_in, .dn_hdr_ready_out, .dn_port_ready_in,
  .dn_port_valid_out);

// *** testbench/hub_upstream_tx_scheduler_tb.sv ***
// Self-checking bench for the upstream transmit scheduler.
// Assumes the scheduler, its constants header and the partner model.
`include "hub_up_tx_consts.vh"
module hub_upstream_tx_scheduler_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // A short SKP interval keeps every scheduling case within a few cycles.
  localparam LIM = 8;
  logic         clk, rst, en, u0, lv, hv, hp, pv, pl, pa, dv;
  logic [31:0]  lw, pd;
  logic [159:0] hd, dd;
  logic [1:0]   dp;
  logic [3:0]   dpr;
  wire          lr, hr, pr, rel, dr;
  wire  [31:0]  sym;
  wire  [2:0]   kind;
  wire  [15:0]  cnt;
  wire  [3:0]   dvo;
  wire  [159:0] dho;
  int           seen [0:7];
  int           error_cnt, check_count;

  hub_upstream_tx_scheduler #(.SKIP_LIMIT(LIM)) u_hub_upstream_tx_scheduler (
    .sys_clk_in(clk), .rst_in(rst), .clk_en_in(en), .link_u0_in(u0),
    .lcmd_valid_in(lv), .lcmd_word_in(lw), .lcmd_ready_out(lr),
    .up_hdr_valid_in(hv), .up_hdr_in(hd), .up_hdr_pay_in(hp),
    .up_hdr_ready_out(hr), .pay_valid_in(pv), .pay_data_in(pd),
    .pay_last_in(pl), .pay_abort_in(pa), .pay_ready_out(pr),
    .pay_release_out(rel), .tx_sym_out(sym), .tx_kind_out(kind),
    .sym_count_out(cnt), .dn_hdr_valid_in(dv), .dn_hdr_port_in(dp),
    .dn_hdr_in(dd), .dn_hdr_ready_out(dr), .dn_port_ready_in(dpr),
    .dn_port_valid_out(dvo), .dn_port_hdr_out(dho));
  up_link_partner u_up_link_partner (.clk_in(clk), .rst_in(rst),
    .kind_in(kind), .seen_out(seen));

  task chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task t_lcmd;
    int c, n, bad, s;
    begin
      c = 0; n = 0; bad = 0; s = 0;
      @(posedge clk) lv <= 1;
      repeat (12) begin
        @(posedge clk);
        if (lr) c++;
        if (c == 3) lv <= 0;
        #1;
        if (kind === `KIND_LCMD) begin
          n++;
          if (sym !== lw) bad++;
        end else if (kind === `KIND_SKP && n == 6) s++;
        else if (n > 0 && n < 6 && kind !== `KIND_SKP) bad++;
      end
      chk(n == 6 && bad == 0, "link commands split");
      chk(seen[`KIND_LCMD] == 6, "partner tally");
      chk(s == 1, "no SKP after link command");
      $display("link command test done");
    end
  endtask

  task t_pay(input bit ab);
    int i, h, ok, nr, nd, ns;
    logic [2:0] ek;
    begin
      i = 0; h = 0; ok = 0; nr = 0; nd = 0; ns = 0; ek = `KIND_IDLE;
      @(posedge clk) begin hv <= 1; hp <= 1; pv <= 1; pd <= 32'h10; end
      @(posedge clk) hv <= 0;
      repeat (30) begin
        @(posedge clk);
        if (pr) begin i++; pd <= 32'h10 + i; pl <= (i == 2 && !ab); end
        if (pr && ab && i == 6) pa <= 1;
        #1;
        if (h == 5) begin ok = (kind === `KIND_DATA); h = 6; end
        if (kind === `KIND_HDR) h++;
        if (kind === `KIND_DATA) begin
          if (sym !== 32'h10 + nd) ok = 0;
          nd++;
        end
        if (kind === `KIND_END || kind === `KIND_ABORT) ek = kind;
        if (kind === `KIND_SKP && ek !== `KIND_IDLE && nr == 0) ns++;
        if (rel === 1'b1) nr++;
      end
      @(posedge clk) begin pv <= 0; pa <= 0; pl <= 0; hp <= 0; end
      chk(ok == 1, "payload not contiguous");
      chk(nr == 1 && nd == (ab ? 6 : 3), "payload resent");
      chk(ek === (ab ? `KIND_ABORT : `KIND_END), "wrong ending");
      if (ab) chk(ns == 2, "abort SKPs not repeated");
      else chk(ns == 2, "end SKPs not repeated");
      $display("payload test done");
    end
  endtask

  task t_queue;
    int n, k, h0;
    logic [2:0] pk, fk;
    begin
      n = 0; k = 0; h0 = seen[`KIND_HDR]; pk = 0; fk = 0;
      @(posedge clk) u0 <= 0;
      @(posedge clk) begin hv <= 1; hd <= '0; end
      repeat (8) begin
        @(posedge clk);
        if (hr) n++;
        hd <= hd + 1;
      end
      @(posedge clk);
      chk(n == 8 && hr === 1'b0, "eight headers not held");
      hv <= 0; lv <= 1; u0 <= 1;
      repeat (150) begin
        @(posedge clk);
        if (lr) lv <= 0;
        #1;
        if (fk == 0 && (kind === `KIND_LCMD || kind === `KIND_HDR)) fk = kind;
        if (kind === `KIND_HDR && pk !== `KIND_HDR) begin
          chk(sym === k[31:0], "header out of order");
          k++;
        end
        pk = kind;
      end
      chk(fk === `KIND_LCMD, "header before link command");
      chk(seen[`KIND_HDR] - h0 == 40, "header symbols lost");
      $display("header queue test done");
    end
  endtask

  task t_u0;
    int i;
    begin
      @(posedge clk) u0 <= 0;
      @(posedge clk) u0 <= 1;
      #1;
      chk(kind === `KIND_IDLE, "not idle after U0 entry");
      chk(cnt === 16'h0, "count not cleared");
      for (i = 0; i < LIM + 4 && kind !== `KIND_SKP; i++) @(posedge clk) #1;
      chk(kind === `KIND_SKP, "no idle SKP");
      $display("U0 entry test done");
    end
  endtask

  // Enable low must freeze the count and hold back the link command pop.
  task t_en;
    logic [15:0] c0;
    logic        p;
    begin
      @(posedge clk) begin en <= 0; lv <= 1; end
      @(posedge clk);
      #1;
      c0 = cnt;
      repeat (3) @(posedge clk);
      #1;
      chk(cnt === c0 && lr === 1'b0, "frozen state moved");
      @(posedge clk) en <= 1;
      @(posedge clk);
      p = lr;
      lv <= 0;
      #1;
      chk(p === 1'b1 && cnt === c0 + 16'h1, "no resume");
      $display("clock enable test done");
    end
  endtask

  task t_dn;
    begin
      @(posedge clk) begin dv <= 1; dp <= 2'h2; dpr <= 4'h4; end
      #1;
      chk(dvo === 4'h4 && dr === 1'b1, "misrouted");
      chk(dho === dd, "header delayed");
      @(posedge clk) dp <= 2'h1;
      #1;
      chk(dvo === 4'h2 && dr === 1'b0, "full port accepted");
      @(posedge clk) dv <= 0;
      $display("dispatch test done");
    end
  endtask

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100us;
    chk(0, "run timed out");
    test_done;
  end
  initial begin
    {rst, u0, lv, hv, hp, pv, pl, pa, dv} = 9'h180;
    lw = 32'hA5;
    en = 1'b1;
    pd = 32'h10;
    hd = '0;
    dd = 160'hBEEF;
    dp = 2'h0;
    dpr = 4'h0;
    error_cnt = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst <= 0;
    t_lcmd;
    t_pay(0);
    t_pay(1);
    t_queue;
    t_u0;
    t_en;
    t_dn;
    test_done;
  end
endmodule

// *** testbench/up_link_partner.sv ***
// Upstream link partner model: tallies each received symbol by kind.
// Assumes a registered kind from the scheduler, one symbol per clock.
module up_link_partner (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] kind_in,
  output int              seen_out [0:7]
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle is tallied too, so the counts stay a plain record per symbol.
  always @(posedge clk_in) begin
    if (rst_in) seen_out <= '{default: 0};
    else seen_out[kind_in] <= seen_out[kind_in] + 1;
  end
endmodule
